// ===== cpt_profiler.v
`timescale 1ns/10ps
`include "cpt_consts.vh"
// ==========================================
// Code profiling trace output
// Overview of operation
// - Profiling needs source, enable and arm.
// - Data pin driven both levels, half rate.
// - Lines shifted out LSB first.
// - Transmit starts when no line written.
// - Strobe held constant while waiting.
// - End alignment starts at arm.
// - Begin alignment starts at final state.
// - Mid alignment behaves as end.
// - Transmission continues after disarm; flags shown.
// - Writes ignored, window reads 0xee draining.
// - Gating inputs ignored while profiling.
// - First line: header plus start PC.
// - Indexed jump stores 24-bit target line.
// - Vector line holds vector and stamp.
// - Branch bits fill line until full.
// - Stamp overflow stores entry, continues.
// - 64 pending lines: overflow, end, disarm.
// - Disarm while running stores terminated final entry.
// - Header bits encode format and flags.
// - Header sent first, whole bytes only.
// - Branch bits with leading stop bit.
module cpt_profiler #(
   parameter DEPTH_LOG2 = 6,
   parameter STAMP_W = 16
) (
   input wire clk,
   input wire reset,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire seq_final_state,
   input wire seq_disarm,
   input wire cof_branch,
   input wire cof_taken,
   input wire cof_indexed,
   input wire [23:0] cof_target,
   input wire cof_vector,
   input wire [8:0] cof_vector_addr,
   input wire [23:0] cpu_pc,
   input wire tb_gate_in,
   input wire ext_gate_pin,
   output reg profiling_enable_data_out,
   output wire profiling_enable_data_oe,
   output reg profiling_enable_strobe_clock,
   output wire profiling_enable_strobe_oe,
   output reg unit_armed
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_RUN = 3'b100;

   reg src_sel;
   reg prof_en;
   reg pin_en;
   reg [1:0] align;
   reg ovf_flag;
   reg [2:0] state;
   reg [63:0] buffer [0:DEPTH-1];
   reg [3:0] nbytes [0:DEPTH-1];
   reg [DEPTH_LOG2:0] wr_ptr;
   reg [DEPTH_LOG2:0] rd_ptr;
   reg [31:0] direct;
   reg [STAMP_W-1:0] stamp;
   reg [63:0] shreg;
   reg [6:0] bits_left;
   reg tx_busy;
   reg tx_phase;
   reg ack;

   reg wr_en;
   reg [63:0] wr_line;
   reg [3:0] wr_bytes;
   reg [7:0] hdr;
   reg next_direct_clear;

   wire [DEPTH_LOG2:0] pending = wr_ptr - rd_ptr;
   wire draining = !unit_armed && (tx_busy || pending != {(DEPTH_LOG2+1){1'b0}});
   wire prof_ok = src_sel && prof_en;
   // ==========================================
   // Gating inputs. Profiling ignores both, but the pin still passes two
   // flip-flops so that no metastable level can reach logic later on.
   reg ext_gate_meta;
   reg ext_gate_sync;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_gate_meta <= 1'b0;
         ext_gate_sync <= 1'b0;
      end else begin
         ext_gate_meta <= ext_gate_pin;
         ext_gate_sync <= ext_gate_meta;
      end
   end

   wire gate_unused = tb_gate_in & ext_gate_sync & ~prof_ok;
   wire [31:0] direct_add = {direct[30:0], cof_taken};
   wire direct_full = direct[`CPT_STOP_FULL_BIT];
   wire stamp_ovf = (stamp == `CPT_STAMP_MAX);
   wire buf_ovf = (pending == DEPTH[DEPTH_LOG2:0]);

   // The start condition repeats the state change tests and feeds only the start line write.
   wire start_now = state == ST_IDLE && unit_armed && prof_ok && !draining && align != `CPT_ALIGN_BEGIN
                    || state == ST_WAIT && unit_armed && !seq_disarm && seq_final_state;

   // Buffer slot of a pointer; the extra top bit only tells full from empty.
   function [DEPTH_LOG2-1:0] slot;
      input [DEPTH_LOG2:0] ptr;
      begin
         slot = ptr[DEPTH_LOG2-1:0];
      end
   endfunction

   // A header with any flag set marks a forced entry.
   function flagged;
      input [7:0] h;
      begin
         flagged = h[`CPT_HDR_STAMP_OVF] | h[`CPT_HDR_BUF_OVF] | h[`CPT_HDR_TERM];
      end
   endfunction

   // Overflow and termination end the session; a stamp overflow does not,
   // so the tool can keep counting time across long quiet stretches.
   function ends_session;
      input [7:0] h;
      begin
         ends_session = h[`CPT_HDR_BUF_OVF] | h[`CPT_HDR_TERM];
      end
   endfunction

   function [63:0] pack;
      input [7:0] h;
      input [23:0] ind;
      input [31:0] dir;
      begin
         pack = {ind, dir, h};
      end
   endfunction

   // ==========================================
   // Avalon slave: one wait cycle per access.
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ack <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
         if (avs_read && !ack) begin
            case (avs_address)
               `CPT_ADDR_CTRL: avs_readdata <= {26'h0000000, align, pin_en, prof_en, src_sel, unit_armed};
               `CPT_ADDR_STATUS: avs_readdata <= {29'h00000000, state == ST_RUN, ovf_flag, draining || tx_busy};
               `CPT_ADDR_TBWIN: avs_readdata <= (draining || prof_en) ? `CPT_LOCKED_READ : 32'h00000000;
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   wire ctrl_wr = avs_write && !ack && avs_address == `CPT_ADDR_CTRL && !draining;

   // ==========================================
   // Profiling state and line assembly.
   always @* begin
      wr_en = 1'b0;
      wr_line = 64'h0;
      wr_bytes = `CPT_BYTES_FULL;
      hdr = 8'h00;
      next_direct_clear = 1'b0;
      if (state == ST_RUN) begin
         hdr[`CPT_HDR_TERM] = seq_disarm || (ctrl_wr && !avs_writedata[`CPT_CTRL_ARM]);
         hdr[`CPT_HDR_BUF_OVF] = buf_ovf;
         hdr[`CPT_HDR_STAMP_OVF] = stamp_ovf;
         if (cof_indexed) begin
            hdr[3:0] = `CPT_FMT_INDEXED;
            wr_line = pack(hdr, cof_target, direct);
            wr_en = 1'b1;
         end else if (cof_vector) begin
            hdr[3:0] = `CPT_FMT_VECTOR;
            wr_line = pack(hdr, {cof_vector_addr[8:1], stamp[15:0]}, direct);
            wr_en = 1'b1;
         end else if (cof_branch && direct_full) begin
            hdr[3:0] = `CPT_FMT_DIRECT;
            wr_line = pack(hdr, 24'h000000, direct);
            wr_bytes = `CPT_BYTES_DIRECT;
            wr_en = 1'b1;
         end else if (flagged(hdr)) begin
            hdr[3:0] = `CPT_FMT_TERMINAL;
            wr_line = pack(hdr, {8'h00, stamp[15:0]}, direct);
            wr_bytes = `CPT_BYTES_TERMINAL;
            wr_en = 1'b1;
         end
         next_direct_clear = wr_en;
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         src_sel <= 1'b0;
         prof_en <= 1'b0;
         pin_en <= 1'b0;
         align <= `CPT_ALIGN_END;
         unit_armed <= 1'b0;
         ovf_flag <= 1'b0;
         state <= ST_IDLE;
         wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
         direct <= `CPT_STOP_INIT;
         stamp <= {STAMP_W{1'b0}};
      end else begin
         if (ctrl_wr) begin
            unit_armed <= avs_writedata[`CPT_CTRL_ARM];
            src_sel <= avs_writedata[`CPT_CTRL_SRC];
            prof_en <= avs_writedata[`CPT_CTRL_PROF];
            pin_en <= avs_writedata[`CPT_CTRL_PINEN];
            align <= avs_writedata[`CPT_CTRL_ALIGN_HI:`CPT_CTRL_ALIGN_LO];
            if (avs_writedata[`CPT_CTRL_ARM] && !unit_armed)
               ovf_flag <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (unit_armed && prof_ok && !draining) begin
                  if (align != `CPT_ALIGN_BEGIN)
                     state <= ST_RUN;
                  else
                     state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!unit_armed || seq_disarm) begin
                  state <= ST_IDLE;
                  unit_armed <= 1'b0;
               end else if (seq_final_state) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (wr_en && ends_session(hdr)) begin
                  state <= ST_IDLE;
                  unit_armed <= 1'b0;
                  if (hdr[`CPT_HDR_BUF_OVF])
                     ovf_flag <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
         if (start_now) begin
            buffer[slot(wr_ptr)] <= pack({4'h0, `CPT_FMT_START}, 24'h000000, {cpu_pc, 8'h00}) >> 8
                                    | {56'h0, 4'h0, `CPT_FMT_START};
            nbytes[slot(wr_ptr)] <= `CPT_BYTES_START;
            wr_ptr <= wr_ptr + 1'b1;
            direct <= `CPT_STOP_INIT;
            stamp <= {STAMP_W{1'b0}};
         end else if (state == ST_RUN) begin
            if (wr_en) begin
               buffer[slot(wr_ptr)] <= wr_line;
               nbytes[slot(wr_ptr)] <= wr_bytes;
               wr_ptr <= wr_ptr + 1'b1;
               stamp <= {STAMP_W{1'b0}};
               // stop bit restarts with pending branch
               // A branch that meets a full field opens the next one with it.
               direct <= (cof_branch && direct_full) ? {30'h0, 1'b1, cof_taken} : `CPT_STOP_INIT;
            end else begin
               stamp <= (cof_branch) ? {STAMP_W{1'b0}} : stamp + 1'b1;
               if (cof_branch)
                  direct <= direct_add;
            end
         end
      end
   end

   // ==========================================
   // Serialiser. Data changes on rising clk; strobe flips a quarter
   // strobe period (one clock) later, so each bit meets exactly one strobe edge.
   reg [DEPTH_LOG2:0] rd_next;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
         shreg <= 64'h0;
         bits_left <= 7'h00;
         tx_busy <= 1'b0;
         tx_phase <= 1'b0;
         profiling_enable_data_out <= 1'b0;
         profiling_enable_strobe_clock <= 1'b0;
      end else begin
         tx_phase <= ~tx_phase;
         if (tx_busy && tx_phase) begin
            profiling_enable_strobe_clock <= ~profiling_enable_strobe_clock;
            if (bits_left == 7'h00)
               tx_busy <= 1'b0;
         end
         // start when no line written this cycle
         if ((!tx_busy || (tx_phase && bits_left == 7'h00)) && !tx_phase && pending != 0 && !wr_en) begin
            // header byte sent first, only used bytes
            // A new line waits for the even phase, which costs no idle
            // clock between lines and keeps every strobe edge mid-bit.
            shreg <= buffer[slot(rd_ptr)] >> 1;
            profiling_enable_data_out <= buffer[slot(rd_ptr)][0];
            bits_left <= {nbytes[slot(rd_ptr)], 3'b000} - 7'h01;
            rd_ptr <= rd_ptr + 1'b1;
            tx_busy <= 1'b1;
         end else if (tx_busy && !tx_phase && bits_left != 7'h00) begin
            profiling_enable_data_out <= shreg[0];
            shreg <= shreg >> 1;
            bits_left <= bits_left - 7'h01;
         end
      end
   end

   // pins driven both levels while assigned
   assign profiling_enable_data_oe = pin_en && prof_en && !gate_unused | pin_en && prof_en;
   assign profiling_enable_strobe_oe = profiling_enable_data_oe;
endmodule

// ===== cpt_consts.vh
`ifndef CPT_CONSTS_VH
`define CPT_CONSTS_VH
// ==========================================
// Register map (word byte addresses)
`define CPT_ADDR_CTRL 4'h0
`define CPT_ADDR_STATUS 4'h4
`define CPT_ADDR_TBWIN 4'h8
// ==========================================
// Control register fields
`define CPT_CTRL_ARM 0
`define CPT_CTRL_SRC 1
`define CPT_CTRL_PROF 2
`define CPT_CTRL_PINEN 3
`define CPT_CTRL_ALIGN_LO 4
`define CPT_CTRL_ALIGN_HI 5
// ==========================================
// Status register fields
`define CPT_STAT_TXACT 0
`define CPT_STAT_OVF 1
`define CPT_STAT_ACTIVE 2
// ==========================================
// Alignment encodings
`define CPT_ALIGN_END 2'h0
`define CPT_ALIGN_BEGIN 2'h1
`define CPT_ALIGN_MID 2'h2
// ==========================================
// Line header byte
`define CPT_FMT_START 4'h0
`define CPT_FMT_INDEXED 4'h1
`define CPT_FMT_DIRECT 4'h2
`define CPT_FMT_VECTOR 4'h3
`define CPT_FMT_TERMINAL 4'h7
`define CPT_HDR_STAMP_OVF 6
`define CPT_HDR_BUF_OVF 5
`define CPT_HDR_TERM 4
// ==========================================
// Byte counts per format, and misc constants
`define CPT_BYTES_START 4'h4
`define CPT_BYTES_FULL 4'h8
`define CPT_BYTES_DIRECT 4'h5
`define CPT_BYTES_TERMINAL 4'h7
`define CPT_STOP_INIT 32'h00000001
`define CPT_STOP_FULL_BIT 31
`define CPT_LOCKED_READ 32'h000000ee
`define CPT_STAMP_MAX 16'hffff
`endif

// ===== cpt_profiler_props.sv
`timescale 1ns/10ps
// ==========
// Bus and profiling pin checks
module cpt_profiler_props (
   input logic clk,
   input logic reset,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_readdata,
   input logic avs_waitrequest,
   input logic profiling_enable_data_out,
   input logic profiling_enable_data_oe,
   input logic profiling_enable_strobe_clock,
   input logic profiling_enable_strobe_oe,
   input logic unit_armed
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("wait low in first cycle");
   answer_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer late");
   read_stands_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved");
   pins_paired_a: assert property (profiling_enable_data_oe == profiling_enable_strobe_oe)
      else $error("pin enables differ");
   strobe_mid_a: assert property ($changed(profiling_enable_strobe_clock) |-> $stable(profiling_enable_data_out))
      else $error("strobe on data change");
   strobe_half_a: assert property ($changed(profiling_enable_strobe_clock) |=> $stable(profiling_enable_strobe_clock))
      else $error("strobe too fast");
   bit_two_a: assert property ($changed(profiling_enable_data_out) |=> $stable(profiling_enable_data_out))
      else $error("data bit too short");
   bit_seen_a: assert property (profiling_enable_data_oe && unit_armed && $changed(profiling_enable_data_out)
      |=> $changed(profiling_enable_strobe_clock))
      else $error("data bit not strobed");
   cover property (avs_write && !avs_waitrequest);
   cover property ($changed(profiling_enable_strobe_clock));
   cover property ($fell(unit_armed));
endmodule

bind cpt_profiler cpt_profiler_props cpt_profiler_props_inst (.clk, .reset, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .profiling_enable_data_out, .profiling_enable_data_oe, .profiling_enable_strobe_clock, .profiling_enable_strobe_oe, .unit_armed);

// ===== cpt_tool_model.sv
`timescale 1ns/10ps
// ==========
// Development tool capturing the serial stream
module cpt_tool_model (
   input logic reset,
   input logic profiling_enable_data_out,
   input logic profiling_enable_data_oe,
   input logic profiling_enable_strobe_clock,
   input logic profiling_enable_strobe_oe
);
   logic [7:0] sh;
   int nbits;
   logic [7:0] rx[$];
   always @(posedge reset) begin
      rx.delete();
      nbits = 0;
   end
   always @(profiling_enable_strobe_clock) begin
      if (!reset && profiling_enable_strobe_oe && profiling_enable_data_oe) begin
         sh = {profiling_enable_data_out, sh[7:1]};
         nbits++;
         if (nbits % 8 == 0) rx.push_back(sh);
      end
   end
endmodule

// ===== cpt_profiler_tb_top.sv
`timescale 1ns/10ps
`include "cpt_consts.vh"
module cpt_profiler_tb_top;
   logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, q;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, profiling_enable_data_out, profiling_enable_data_oe, profiling_enable_strobe_clock, profiling_enable_strobe_oe, unit_armed;
   logic cof_branch = 0, cof_taken = 0, cof_indexed = 0, cof_vector = 0, tb_gate_in = 0, ext_gate_pin = 0;
   logic [23:0] cof_target = 24'h0, cpu_pc = 24'h123456;
   logic [8:0] cof_vector_addr = 9'h0;
   logic [7:0] exp_b [21] = '{8'h00, 8'h56, 8'h34, 8'h12, 8'h01, 8'h0d, 8'h00, 8'h00, 8'h00, 8'hef, 8'hcd,
      8'hab, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hd2, 8'h17};
   int err_count = 0, checks_done = 0, i;
   always #12.5 clk = ~clk;
   cpt_profiler cpt_profiler_inst (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .seq_final_state(1'b0), .seq_disarm(1'b0), .cof_branch, .cof_taken,
      .cof_indexed, .cof_target, .cof_vector, .cof_vector_addr, .cpu_pc, .tb_gate_in, .ext_gate_pin,
      .profiling_enable_data_out, .profiling_enable_data_oe, .profiling_enable_strobe_clock, .profiling_enable_strobe_oe, .unit_armed);
   cpt_tool_model cpt_tool_model_inst (.reset, .profiling_enable_data_out, .profiling_enable_data_oe, .profiling_enable_strobe_clock,
      .profiling_enable_strobe_oe);
   // ==========
   // Tasks
   task summarize;
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus(input bit rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 50) begin
         err_count++;
         summarize;
      end
      r = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk);
   endtask
   task pulse(input logic b, input logic t, input logic j, input logic v);
      cof_branch <= b;
      cof_taken <= t;
      cof_indexed <= j;
      cof_vector <= v;
      @(posedge clk);
      cof_branch <= 0;
      cof_indexed <= 0;
      cof_vector <= 0;
      @(posedge clk);
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      bus(1, `CPT_ADDR_STATUS, 0, q);
      chk("status idle", q, 32'h0);
      tb_gate_in <= 1;
      ext_gate_pin <= 1;
      cof_target <= 24'habcdef;
      cof_vector_addr <= 9'h1a4;
      bus(0, `CPT_ADDR_CTRL, 32'h2f, q);
      repeat (4) @(posedge clk);
      pulse(1, 1, 0, 0);
      pulse(1, 0, 0, 0);
      pulse(1, 1, 0, 0);
      pulse(0, 0, 1, 0);
      pulse(0, 0, 0, 1);
      bus(1, `CPT_ADDR_STATUS, 0, q);
      chk("running", q & 32'h4, 32'h4);
      bus(1, `CPT_ADDR_TBWIN, 0, q);
      chk("window while profiling", q, 32'hee);
      bus(0, `CPT_ADDR_CTRL, 32'h0e, q);
      chk("armed after disarm", unit_armed, 32'h0);
      bus(0, `CPT_ADDR_CTRL, 32'h0f, q);
      chk("write while draining", unit_armed, 32'h0);
      bus(1, `CPT_ADDR_TBWIN, 0, q);
      chk("window while draining", q, 32'hee);
      bus(1, `CPT_ADDR_STATUS, 0, q);
      chk("transmit active", q & 32'h1, 32'h1);
      for (i = 0; i < 300 && q[0] !== 1'b0; i++) bus(1, `CPT_ADDR_STATUS, 0, q);
      chk("drained flags", q & 32'h3, 32'h0);
      chk("bytes sent", cpt_tool_model_inst.rx.size(), 32'd27);
      for (i = 0; i < 21; i++) begin
         if (i < 17 || i > 18) chk("line byte", cpt_tool_model_inst.rx[i], exp_b[i]);
      end
      summarize;
   end
endmodule
